// >>> hdl/dlo_pkg.sv
// Package for the deserializer lock and output-state controller.
// Assumes a single 100 MHz system clock and synchronous pin inputs.
package dlo_pkg;

  localparam int DLO_LANES = 4;
  localparam int DLO_SSC_W = 3;
  localparam int DLO_FIFO_W = 4;
  localparam int DLO_FIFO_D = 16;

  // Spread modulation dividers per range and code group.
  localparam int DLO_DIV_LF_LO = 625;
  localparam int DLO_DIV_LF_HI = 385;
  localparam int DLO_DIV_HF_LO = 2168;
  localparam int DLO_DIV_HF_HI = 1300;
  localparam int DLO_DIV_W = 12;

  // Codes at or above this use the second divider; all zeros is off.
  localparam logic [2:0] DLO_SSC_OFF = 3'h0;
  localparam logic [2:0] DLO_SSC_HI_GRP = 3'h5;

  // Time without embedded clock bits before sleep, minimum acquisition time before lock, and their cycle counts.
  localparam int DLO_CLK_MHZ = 100;
  localparam int DLO_STOP_NS = 400;
  localparam int DLO_STOP_CYC = DLO_STOP_NS * DLO_CLK_MHZ / 1000;
  localparam int DLO_ACQ_NS = 1000;
  localparam int DLO_ACQ_CYC = DLO_ACQ_NS * DLO_CLK_MHZ / 1000;
  localparam int DLO_CNT_W = 12;

  // Reset value of the serial-bus configuration shadow.
  localparam logic [7:0] DLO_CFG_RST = 8'h00;

  typedef enum logic [1:0] {
    DLO_OFF,
    DLO_ACQUIRE,
    DLO_LOCKED,
    DLO_SLEEP
  } dlo_state_t;

  // Output driver bundle: value plus active-low enable.
  typedef struct packed {
    logic clk;
    logic clk_oe_n;
    logic [DLO_LANES-1:0] data;
    logic data_oe_n;
    logic pass;
    logic pass_oe_n;
  } dlo_drive_t;

endpackage : dlo_pkg

// >>> hdl/dlo_fifo.sv
// Small synchronous FIFO for the recovered parallel data path.
// Assumes one clock; read data come from a register.
`timescale 1ns/10ps
module dlo_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic reset_n_in, // Asynchronous reset, active low.
  input wire logic flush_in, // Empty the buffer.
  input wire logic [WIDTH-1:0] wr_data_in, // Write word.
  input wire logic wr_valid_in, // Write request.
  output logic wr_ready_out, // Space available.
  output logic [WIDTH-1:0] rd_data_out, // Read word.
  output logic rd_valid_out, // Read word valid.
  input wire logic rd_ready_in // Consumer takes word.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] count_q;
  logic do_wr;
  logic do_rd;

  // The output register counts as one slot beyond the array.
  assign do_rd = (count_q != '0) && (!rd_valid_out || rd_ready_in);
  assign do_wr = wr_valid_in && wr_ready_out;

  // Storage array; no reset, so it maps to plain memory.
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem_q[wptr_q] <= wr_data_in;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      wr_ready_out <= 1'b0;
    end else if (flush_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      wr_ready_out <= 1'b1;
    end else begin
      if (do_wr) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (do_rd) begin
        rptr_q <= rptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      wr_ready_out <= (count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd))
                      < (AW+1)'(DEPTH);
    end
  end

  // Registered read port.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else if (flush_in) begin
      rd_valid_out <= 1'b0;
    end else if (do_rd) begin
      rd_data_out <= mem_q[rptr_q];
      rd_valid_out <= 1'b1;
    end else if (rd_ready_in) begin
      rd_valid_out <= 1'b0;
    end
  end

endmodule : dlo_fifo

// >>> hdl/dlo_ctrl.sv
// Lock status and output-state controller of the deserializer.
// Assumes clock recovery supplies lock and embedded-clock indications,
// recovered clock and data as synchronous levels, and that the self-test
// checker supplies its run level and error pulses; pads resolve the active-low enables.
`timescale 1ns/10ps

module dlo_ctrl
  import dlo_pkg::*;
#(
  parameter int LANES = DLO_LANES,
  parameter int FIFO_DEPTH = DLO_FIFO_D
) (
  input wire logic clk_sys_in, // System clock, 100 MHz.
  input wire logic reset_n_in, // Asynchronous reset, active low.
  input wire logic power_down_n_in, // Host power control, low = down.
  input wire logic output_drive_enable_in, // Output enable, high = drive.
  input wire logic output_idle_state_select_in, // Idle-state select.
  input wire logic fallback_osc_select_in, // Oscillator on idle clock.
  input wire logic fallback_osc_clock_in, // Internal oscillator level.
  input wire logic embedded_clock_present_in, // Clock bits seen.
  input wire logic cdr_acquired_in, // Recovery loop has locked.
  input wire logic recovered_clock_in, // Recovered clock level.
  input wire logic [LANES-1:0] recovered_data_in, // Recovered lanes.
  input wire logic recovered_data_valid_in, // Recovered word strobe.
  output logic recovered_data_ready_out, // Buffer can take a word.
  input wire logic [DLO_SSC_W-1:0] spread_profile_select_in, // Profile.
  input wire logic low_rate_range_in, // High for 5 to 20 MHz clocks.
  input wire logic selftest_active_in, // Self-test running.
  input wire logic selftest_error_in, // Payload error pulse.
  input wire logic cfg_write_in, // Serial-bus configuration write.
  input wire logic [7:0] cfg_wdata_in, // Configuration byte.
  output logic [7:0] cfg_rdata_out, // Configuration read-back.
  output logic clock_data_recovery_run_out, // Acquisition enabled.
  output logic link_locked_out, // Link lock status.
  output logic sleep_out, // Low-power sleep.
  output logic spread_active_out, // Modulation running.
  output logic spread_tick_out, // Modulation period pulse.
  output logic recovered_clock_out, // Clock pin value.
  output logic recovered_clock_oe_n_out, // Clock pin enable, low.
  output logic [LANES-1:0] parallel_data_out, // Data pins.
  output logic parallel_data_oe_n_out, // Data enable, low.
  output logic selftest_result_out, // Result pin value.
  output logic selftest_result_oe_n_out // Result enable, low.
);

  dlo_state_t state_q;
  logic [DLO_CNT_W-1:0] stop_cnt_q;
  logic [DLO_CNT_W-1:0] acq_cnt_q;
  logic [7:0] cfg_q;
  logic pass_q;
  logic st_act_q;
  logic clk_src_osc_q;
  logic clk_hold_q;
  logic [DLO_DIV_W-1:0] div_cnt_q;
  logic [DLO_DIV_W-1:0] div_lim;
  logic stream_lost;
  logic locked;
  logic [LANES-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_flush;
  dlo_drive_t drv_d;

  // Divider chosen from range and code group.
  function automatic logic [DLO_DIV_W-1:0] spread_div(
    input logic lf, input logic [DLO_SSC_W-1:0] code);
    logic hi;
    hi = (code >= DLO_SSC_HI_GRP);
    if (lf) begin
      spread_div = hi ? DLO_DIV_W'(DLO_DIV_LF_HI)
                      : DLO_DIV_W'(DLO_DIV_LF_LO);
    end else begin
      spread_div = hi ? DLO_DIV_W'(DLO_DIV_HF_HI)
                      : DLO_DIV_W'(DLO_DIV_HF_LO);
    end
  endfunction : spread_div

  assign stream_lost = (stop_cnt_q >= DLO_CNT_W'(DLO_STOP_CYC));
  assign locked = (state_q == DLO_LOCKED);
  assign fifo_flush = !locked;

  // Counts cycles without embedded clock bits; short gaps are ignored.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stop_cnt_q <= '0;
    end else if (embedded_clock_present_in || !power_down_n_in) begin
      stop_cnt_q <= '0;
    end else if (!stream_lost) begin
      stop_cnt_q <= stop_cnt_q + 1'b1;
    end
  end

  // Link state machine; every change except the asynchronous reset lands on a clock edge.
  // registered lock
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= DLO_OFF;
      acq_cnt_q <= '0;
    end else if (!power_down_n_in) begin
      state_q <= DLO_OFF;
      acq_cnt_q <= '0;
    end else begin
      unique case (state_q)
        DLO_OFF: begin
          state_q <= DLO_ACQUIRE;
          acq_cnt_q <= '0;
        end
        DLO_ACQUIRE: begin
          if (stream_lost) begin
            state_q <= DLO_SLEEP;
          end else if (cdr_acquired_in &&
                       acq_cnt_q >= DLO_CNT_W'(DLO_ACQ_CYC)) begin
            state_q <= DLO_LOCKED;
          end else if (acq_cnt_q < DLO_CNT_W'(DLO_ACQ_CYC)) begin
            acq_cnt_q <= acq_cnt_q + 1'b1;
          end
        end
        DLO_LOCKED: begin
          if (stream_lost || !cdr_acquired_in) begin
            state_q <= stream_lost ? DLO_SLEEP : DLO_ACQUIRE;
            acq_cnt_q <= '0;
          end
        end
        DLO_SLEEP: begin
          if (embedded_clock_present_in) begin
            state_q <= DLO_ACQUIRE;
            acq_cnt_q <= '0;
          end
        end
      endcase
    end
  end

  // Serial-bus configuration shadow.
  // reset on power-down; kept in sleep
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q <= DLO_CFG_RST;
    end else if (!power_down_n_in) begin
      cfg_q <= DLO_CFG_RST;
    end else if (cfg_write_in) begin
      cfg_q <= cfg_wdata_in;
    end
  end

  // Self-test result: an error during the run wins over the start clear.
  // hold result
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pass_q <= 1'b1;
      st_act_q <= 1'b0;
    end else if (!power_down_n_in) begin
      pass_q <= 1'b1;
      st_act_q <= 1'b0;
    end else begin
      st_act_q <= selftest_active_in;
      if (selftest_active_in && selftest_error_in) begin
        pass_q <= 1'b0;
      end else if (selftest_active_in && !st_act_q) begin
        pass_q <= 1'b1;
      end
    end
  end

  // Clock source: switch only once the incoming source sits at the held level.
  // glitch-free switch
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_src_osc_q <= 1'b0;
      clk_hold_q <= 1'b0;
    end else begin
      if (clk_src_osc_q == locked) begin
        if ((locked ? recovered_clock_in : fallback_osc_clock_in)
            == clk_hold_q) begin
          clk_src_osc_q <= !locked;
        end
      end else begin
        clk_hold_q <= clk_src_osc_q ? fallback_osc_clock_in
                                    : recovered_clock_in;
      end
    end
  end

  // Modulation period counter.
  // zero code off
  assign div_lim = spread_div(low_rate_range_in, spread_profile_select_in);
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_q <= '0;
      spread_tick_out <= 1'b0;
      spread_active_out <= 1'b0;
    end else if (!locked || spread_profile_select_in == DLO_SSC_OFF) begin
      div_cnt_q <= '0;
      spread_tick_out <= 1'b0;
      spread_active_out <= 1'b0;
    end else begin
      spread_active_out <= 1'b1;
      if (div_cnt_q >= div_lim - 1'b1) begin
        div_cnt_q <= '0;
        spread_tick_out <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
        spread_tick_out <= 1'b0;
      end
    end
  end

  // Data buffer; drains one word per cycle while locked and enabled.
  dlo_fifo #(
    .WIDTH(LANES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .flush_in(fifo_flush),
    .wr_data_in(recovered_data_in),
    .wr_valid_in(recovered_data_valid_in),
    .wr_ready_out(recovered_data_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(output_drive_enable_in)
  );

  // Output state table; enables are active low.
  always_comb begin
    drv_d = '{clk: 1'b0, clk_oe_n: 1'b1, data: '0, data_oe_n: 1'b1,
              pass: 1'b1, pass_oe_n: 1'b1};
    if (!power_down_n_in) begin
      drv_d.pass_oe_n = output_idle_state_select_in;
    end else if (locked) begin
      if (output_drive_enable_in) begin
        drv_d.clk = clk_src_osc_q ? clk_hold_q : recovered_clock_in;
        drv_d.clk_oe_n = 1'b0;
        drv_d.data = fifo_valid ? fifo_data : parallel_data_out;
        drv_d.data_oe_n = 1'b0;
        drv_d.pass = pass_q;
        drv_d.pass_oe_n = 1'b0;
      end else begin
        drv_d.pass_oe_n = 1'b0;
      end
    end else if (output_drive_enable_in && output_idle_state_select_in
                 && cfg_q[0] && fallback_osc_select_in) begin
      drv_d.clk = clk_src_osc_q ? fallback_osc_clock_in : clk_hold_q;
      drv_d.clk_oe_n = 1'b0;
    end else if (!output_idle_state_select_in) begin
      drv_d.pass_oe_n = 1'b0;
    end
  end

  // Registered pins and status.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      recovered_clock_out <= 1'b0;
      recovered_clock_oe_n_out <= 1'b1;
      parallel_data_out <= '0;
      parallel_data_oe_n_out <= 1'b1;
      selftest_result_out <= 1'b1;
      selftest_result_oe_n_out <= 1'b1;
      link_locked_out <= 1'b0;
      sleep_out <= 1'b0;
      clock_data_recovery_run_out <= 1'b0;
      cfg_rdata_out <= DLO_CFG_RST;
    end else begin
      recovered_clock_out <= drv_d.clk;
      recovered_clock_oe_n_out <= drv_d.clk_oe_n;
      parallel_data_out <= drv_d.data;
      parallel_data_oe_n_out <= drv_d.data_oe_n;
      selftest_result_out <= drv_d.pass;
      selftest_result_oe_n_out <= drv_d.pass_oe_n;
      link_locked_out <= locked;
      sleep_out <= (state_q == DLO_SLEEP);
      clock_data_recovery_run_out <= (state_q == DLO_ACQUIRE) || locked;
      cfg_rdata_out <= cfg_q;
    end
  end

endmodule : dlo_ctrl

// >>> verif/dlo_ctrl_asserts.sv
// Checker for the lock and output-state controller, bound to its ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/10ps
module dlo_ctrl_asserts
  import dlo_pkg::*;
(
  input wire logic clk_sys_in, // Clock.
  input wire logic reset_n_in, // Reset.
  input wire logic power_down_n_in, // Power.
  input wire logic output_drive_enable_in, // Enable.
  input wire logic output_idle_state_select_in, // Idle select.
  input wire logic embedded_clock_present_in, // Clock bits.
  input wire logic cdr_acquired_in, // Loop locked.
  input wire logic [DLO_SSC_W-1:0] spread_profile_select_in, // Profile.
  input wire logic low_rate_range_in, // Range.
  input wire logic cfg_write_in, // Write.
  input wire logic [7:0] cfg_rdata_out, // Read-back.
  input wire logic link_locked_out, // Lock.
  input wire logic sleep_out, // Sleep.
  input wire logic spread_tick_out, // Tick.
  input wire logic recovered_clock_oe_n_out, // Clock enable.
  input wire logic parallel_data_oe_n_out, // Data enable.
  input wire logic selftest_result_oe_n_out // Result enable.
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  logic [11:0] up_q, dark_q, gap_q;
  logic clean_q;
  // Saturating counts of good and missing stream and of tick spacing; a
  // spacing is trusted only when nothing steering the divider has moved.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_q <= 12'h000;
      dark_q <= 12'h000;
      gap_q <= 12'h000;
      clean_q <= 1'b0;
    end else begin
      if (power_down_n_in && embedded_clock_present_in && cdr_acquired_in)
        up_q <= up_q + 12'(up_q < 12'h0C8);
      else
        up_q <= 12'h000;
      if (power_down_n_in && !embedded_clock_present_in)
        dark_q <= dark_q + 12'(dark_q < 12'h064);
      else
        dark_q <= 12'h000;
      gap_q <= spread_tick_out ? 12'h001 : gap_q + 12'(gap_q < 12'hFA0);
      clean_q <= (spread_tick_out | clean_q) & $stable({low_rate_range_in,
        spread_profile_select_in, link_locked_out, sleep_out});
    end
  end
  // Output states against lock, power and enable.
  sequence s_on;
    power_down_n_in && output_drive_enable_in && link_locked_out;
  endsequence
  sequence s_idle;
    power_down_n_in && output_drive_enable_in && !link_locked_out
      && output_idle_state_select_in;
  endsequence
  sequence s_tick;
    spread_tick_out && clean_q && $stable(spread_profile_select_in)
      && $stable(low_rate_range_in);
  endsequence
  property p_acq_lock;
    up_q == 12'h0C8 |-> link_locked_out;
  endproperty
  property p_normal;
    s_on [*2] |-> !recovered_clock_oe_n_out && !parallel_data_oe_n_out
      && !selftest_result_oe_n_out;
  endproperty
  property p_oe_off;
    !output_drive_enable_in [*2] |-> recovered_clock_oe_n_out
      && parallel_data_oe_n_out;
  endproperty
  property p_idle;
    s_idle [*2] |-> parallel_data_oe_n_out && selftest_result_oe_n_out;
  endproperty
  property p_pd_float;
    !power_down_n_in [*3] |-> recovered_clock_oe_n_out
      && parallel_data_oe_n_out && !link_locked_out;
  endproperty
  property p_pd_cfg;
    !power_down_n_in [*3] |-> cfg_rdata_out == DLO_CFG_RST;
  endproperty
  property p_sleep;
    dark_q == 12'h064 |-> sleep_out && !link_locked_out;
  endproperty
  property p_keep;
    (sleep_out && power_down_n_in && !cfg_write_in) [*3] |=>
      $stable(cfg_rdata_out);
  endproperty
  property p_div;
    s_tick |-> gap_q == (low_rate_range_in ?
      (spread_profile_select_in >= DLO_SSC_HI_GRP ? DLO_DIV_LF_HI :
      DLO_DIV_LF_LO) : (spread_profile_select_in >= DLO_SSC_HI_GRP ?
      DLO_DIV_HF_HI : DLO_DIV_HF_LO));
  endproperty
  a_acq_lock: assert property (p_acq_lock)
    else $error("lock missing after acquisition");
  a_normal: assert property (p_normal)
    else $error("outputs not driven while locked");
  a_oe_off: assert property (p_oe_off)
    else $error("outputs driven while disabled");
  a_idle: assert property (p_idle)
    else $error("data or result driven while unlocked");
  a_pd_float: assert property (p_pd_float)
    else $error("outputs driven while powered down");
  a_pd_cfg: assert property (p_pd_cfg)
    else $error("configuration kept in power-down");
  a_sleep: assert property (p_sleep)
    else $error("no sleep on missing clock bits");
  a_keep: assert property (p_keep)
    else $error("configuration changed in sleep");
  a_div: assert property (p_div)
    else $error("modulation period wrong");
endmodule : dlo_ctrl_asserts

bind dlo_ctrl dlo_ctrl_asserts chk_u (.*);

// >>> verif/dlo_ser_model.sv
// Upstream serializer model feeding the recovered stream indications.
// Assumes the bench starts and stops the stream with run_in.
`timescale 1ns/10ps
module dlo_ser_model #(
  parameter int ACQ = 20
) (
  input wire logic clk_sys_in, // Clock.
  input wire logic run_in, // Stream on.
  input wire logic ready_in, // Word taken.
  output logic present_out, // Clock bits.
  output logic acquired_out, // Loop locked.
  output logic rclk_out, // Clock level.
  output logic [3:0] data_out, // Lane word.
  output logic valid_out // Word valid.
);
  int cnt = 0;
  logic took = 1'b0;
  initial {present_out, acquired_out, rclk_out, valid_out} = 4'h0;
  initial data_out = 4'hA;
  // A word advances only after the block has taken it at a rising edge.
  always @(posedge clk_sys_in) took <= valid_out & ready_in;
  // Changes land on the falling edge; the clock stands still off-stream
  // and idle lanes toggle so a stale value never looks valid.
  always @(negedge clk_sys_in) begin
    cnt <= run_in ? cnt + 1 : 0;
    present_out <= run_in;
    acquired_out <= run_in && cnt >= ACQ;
    rclk_out <= run_in & ~rclk_out;
    valid_out <= run_in;
    if (!run_in)
      data_out <= ~data_out;
    else if (took)
      data_out <= data_out + 4'h1;
  end
endmodule : dlo_ser_model

// >>> verif/dlo_ctrl_bench.sv
// Self-checking bench for the lock and output-state controller.
// Assumes the serializer model and the checker are compiled beside it.
`timescale 1ns/10ps
module dlo_ctrl_bench
  import dlo_pkg::*;
;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, power_down_n_in = 1'b0;
  logic output_drive_enable_in = 1'b0, output_idle_state_select_in = 1'b0;
  logic fallback_osc_select_in = 1'b0, fallback_osc_clock_in = 1'b0;
  logic embedded_clock_present_in, cdr_acquired_in, recovered_clock_in;
  logic [3:0] recovered_data_in, parallel_data_out;
  logic recovered_data_valid_in, recovered_data_ready_out;
  logic [2:0] spread_profile_select_in = 3'h0;
  logic low_rate_range_in = 1'b0, selftest_active_in = 1'b0;
  logic selftest_error_in = 1'b0, cfg_write_in = 1'b0, run = 1'b0;
  logic [7:0] cfg_wdata_in = 8'h00, cfg_rdata_out, w;
  logic clock_data_recovery_run_out, link_locked_out, sleep_out;
  logic spread_active_out, spread_tick_out, recovered_clock_out;
  logic recovered_clock_oe_n_out, parallel_data_oe_n_out;
  logic selftest_result_out, selftest_result_oe_n_out;
  logic [15:0] gap = 16'h0000;
  logic [31:0] e;
  logic [31:0] sq[$];
  logic [15:0] tq[$];
  int i, j, k, seed, n_fail = 0, num_checks = 0;
  wire [15:0] obs = {recovered_data_ready_out, link_locked_out, sleep_out,
    recovered_clock_oe_n_out, parallel_data_oe_n_out, selftest_result_out,
    selftest_result_oe_n_out, spread_active_out, cfg_rdata_out};

  dlo_ctrl dut_u (.*);
  dlo_ser_model ser_u (.clk_sys_in, .run_in(run),
    .ready_in(recovered_data_ready_out),
    .present_out(embedded_clock_present_in), .acquired_out(cdr_acquired_in),
    .rclk_out(recovered_clock_in), .data_out(recovered_data_in),
    .valid_out(recovered_data_valid_in));

  // Clock and a free-running oscillator level.
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) fallback_osc_clock_in <= ~fallback_osc_clock_in;

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic timed_out();
    n_fail++;
    print_verdict();
  endtask : timed_out

  task automatic cmp(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp

  task automatic go(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : go

  // Waits, with a bound, until the monitor has used every note.
  task automatic wq();
    int n;
    for (n = 0; n < 5000 && sq.size() + tq.size() > 0; n++) go(1);
    if (n == 5000) timed_out();
  endtask : wq

  // Notes masked expected outputs for the monitor.
  task automatic st(input logic [15:0] m, input logic [15:0] x);
    sq.push_back({m, x});
    wq();
  endtask : st

  task automatic wr(input logic [7:0] d);
    cfg_wdata_in = d;
    cfg_write_in = 1'b1;
    go(1);
    cfg_write_in = 1'b0;
    go(3);
  endtask : wr

  task automatic wait_lock();
    int n;
    for (n = 0; n < 300 && link_locked_out !== 1'b1; n++) go(1);
    if (n == 300) timed_out();
    go(3);
  endtask : wait_lock

  function automatic logic [15:0] div(input logic lf, input logic [2:0] c);
    int d;
    if (lf)
      d = c >= DLO_SSC_HI_GRP ? DLO_DIV_LF_HI : DLO_DIV_LF_LO;
    else
      d = c >= DLO_SSC_HI_GRP ? DLO_DIV_HF_HI : DLO_DIV_HF_LO;
    return d[15:0];
  endfunction : div

  // Compares settled outputs just after each edge; tick spacing is counted
  // here so the driver never has to meet the edge itself.
  always @(posedge clk_sys_in) begin
    #1;
    gap++;
    if (spread_tick_out === 1'b1) begin
      if (tq.size() > 0)
        cmp(gap, tq.pop_front());
      gap = 16'h0000;
    end
    if (sq.size() > 0) begin
      e = sq.pop_front();
      cmp(obs & e[31:16], e[15:0]);
    end
  end

  // Main sequence of scenarios.
  initial begin
    seed = 51;
    go(15);
    st(16'hDEFF, 16'h1E00);
    reset_n_in = 1'b1;
    go(2);
    wr(8'hA5);
    st(16'h58FF, 16'h1800); // write refused
    $display("Power-down test done");
    power_down_n_in = 1'b1; // host holds power on
    run = 1'b1;
    output_idle_state_select_in = 1'b1;
    output_drive_enable_in = 1'b1;
    w = 8'($random(seed));
    w[0] = 1'b1;
    wr(w);
    st(16'h5AFF, {8'h1A, w}); // acquiring
    fallback_osc_select_in = 1'b1;
    go(2);
    st(16'h5A00, 16'h0A00); // oscillator out
    wait_lock();
    st(16'h7A00, 16'h4000); // locked
    $display("Lock test done");
    for (i = 0; i < 16; i++) begin
      {low_rate_range_in, spread_profile_select_in} = i[3:0];
      go(4);
      st(16'h0100, {7'h00, i[2:0] != 3'h0, 8'h00});
      if (i[2:0] != 3'h0) begin
        for (j = 0; j < 3000 && spread_tick_out !== 1'b1; j++) go(1);
        if (j == 3000) timed_out();
        tq.push_back(div(i[3], i[2:0]));
        wq();
      end
    end
    $display("Spread test done");
    output_drive_enable_in = 1'b0;
    for (i = 0; i < 60 && recovered_data_ready_out !== 1'b0; i++) go(1);
    if (i == 60) timed_out();
    st(16'hDE00, 16'h5C00); // full buffer
    output_drive_enable_in = 1'b1;
    go(30);
    st(16'hFA00, 16'hC000); // drained
    // Draining keeps one word a cycle flowing, so lanes count up by one.
    k = {recovered_clock_out, parallel_data_out};
    go(1);
    cmp({10'h000, clock_data_recovery_run_out, recovered_clock_out,
      parallel_data_out}, {10'h000, 1'b1, ~k[4], k[3:0] + 4'h1});
    for (k = 0; k < 2; k++) begin
      selftest_active_in = 1'b1;
      go(2 + ($random(seed) & 7));
      selftest_error_in = ~k[0];
      go(1);
      selftest_error_in = 1'b0;
      go(4);
      selftest_active_in = 1'b0;
      go(3);
      st(16'h0600, {5'h00, k[0], 10'h000}); // result
    end
    $display("Enable and self-test done");
    run = 1'b0;
    for (i = 0; i < 200 && sleep_out !== 1'b1; i++) go(1);
    if (i == 200) timed_out();
    go(5);
    st(16'h60FF, {8'h20, w}); // asleep
    run = 1'b1;
    wait_lock();
    st(16'h7A00, 16'h4000); // relocked
    power_down_n_in = 1'b0;
    go(4);
    st(16'h58FF, 16'h1800); // cleared
    $display("Sleep test done");
    print_verdict();
  end
endmodule : dlo_ctrl_bench
